/* hdl/supervisor_pkg.sv */
// Constants shared by the supervisory reset and watchdog block
package supervisor_pkg;

  // Clock
  localparam longint CLK_HZ        = 64'd20_000_000;
  localparam int     CLK_PERIOD_NS = 50;

  // Power-up reset timeout, milliseconds
  localparam longint PURST_TYP_MS = 64'd200;
  localparam longint PURST_MIN_MS = 64'd130;
  localparam longint PURST_MAX_MS = 64'd270;

  // Watchdog period, seconds
  localparam real    WDOG_PERIOD_S = 1.6;

  // Internal write time, milliseconds (maximum)
  localparam longint WR_MAX_MS = 64'd10;

  // Host wait after supply stable, milliseconds
  localparam longint PU_RD_DELAY_MS = 64'd1;
  localparam longint PU_WR_DELAY_MS = 64'd1;

  // Cycle counts derived from the times
  localparam int unsigned PURST_CYC = int'((PURST_TYP_MS * CLK_HZ) / 64'd1000);
  localparam int unsigned PURST_MIN_CYC = int'((PURST_MIN_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam int unsigned PURST_MAX_CYC = int'((PURST_MAX_MS * CLK_HZ) / 64'd1000);
  localparam int unsigned WDOG_CYC = int'($rtoi(WDOG_PERIOD_S * real'(CLK_HZ)));
  localparam int unsigned WR_CYC = int'((WR_MAX_MS * CLK_HZ) / 64'd1000);

  // Counter width, enough for the longest timeout
  localparam int CNT_W = 32;

  // Reset sequencer states
  typedef enum logic [2:0] {
    ST_UNDERV  = 3'b001,
    ST_TIMEOUT = 3'b010,
    ST_RUN     = 3'b100
  } rst_state_t;

endpackage : supervisor_pkg

/* hdl/pin_sync_edge.sv */
// Two-flop pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge #(
  parameter logic IDLE_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  // Pin
  input  wire logic pin_i,
  // Synchronised view
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // Idle value avoids a false edge right after reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      meta_r <= IDLE_VAL;
      sync_r <= IDLE_VAL;
      last_r <= IDLE_VAL;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level_o = sync_r;
  assign rise_o  = sync_r & ~last_r;
  assign fall_o  = ~sync_r & last_r;

endmodule : pin_sync_edge
`default_nettype wire

/* hdl/supervisory_reset_watchdog.sv */
// Reset sequencer, watchdog and memory write gating of the supervisor
`timescale 1ns/1ps
`default_nettype none
module supervisory_reset_watchdog #(
  parameter int unsigned PURST_CYC = supervisor_pkg::PURST_CYC,
  parameter int unsigned WDOG_CYC  = supervisor_pkg::WDOG_CYC,
  parameter int unsigned WR_CYC    = supervisor_pkg::WR_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  // Supply comparator, same clock domain
  input  wire logic undervolt_i,
  // Watchdog pin
  input  wire logic watchdog_kick_in_i,
  // Active-high reset line
  input  wire logic rst_hi_i,
  output logic      rst_hi_o,
  output logic      rst_hi_oe_o,
  // Active-low reset line
  input  wire logic rst_n_i,
  output logic      rst_n_o,
  output logic      rst_n_oe_o,
  // Write protect pin
  input  wire logic write_protect_i,
  // Requests from the serial protocol engine
  input  wire logic ack_addr_req_i,
  input  wire logic ack_data_req_i,
  input  wire logic rd_low_req_i,
  input  wire logic write_stop_i,
  // Serial data line
  output logic      sda_o,
  output logic      sda_oe_o,
  // Status
  output logic      reset_active_o,
  output logic      bus_enable_o,
  output logic      prog_start_o,
  output logic      prog_busy_o,
  output logic      wdog_timeout_o
);

  localparam int CW = supervisor_pkg::CNT_W;

  function automatic logic [CW-1:0] last_cnt(input int unsigned cyc);
    last_cnt = CW'(cyc - 1);
  endfunction : last_cnt

  supervisor_pkg::rst_state_t state_r;

  logic          kick_edge;
  logic          kick_rise;
  logic          kick_fall;
  logic          hi_rise;
  logic          n_fall;
  logic          wp_level;
  logic          ext_req;
  logic          rst_active;
  logic [CW-1:0] pu_cnt_r;
  logic [CW-1:0] wd_cnt_r;
  logic          wd_to;
  logic [CW-1:0] wr_cnt_r;
  logic          busy_r;
  logic          start_r;
  logic          prog_go;
  logic          bus_en;
  logic          sda_oe_r;
  logic          sda_oe_nxt;

  // Pin synchronisers
  pin_sync_edge #(.IDLE_VAL(1'b0)) u_kick (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pin_i     (watchdog_kick_in_i),
    .level_o   (),
    .rise_o    (kick_rise),
    .fall_o    (kick_fall)
  );

  pin_sync_edge #(.IDLE_VAL(1'b0)) u_rst_hi (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pin_i     (rst_hi_i),
    .level_o   (),
    .rise_o    (hi_rise),
    .fall_o    ()
  );

  pin_sync_edge #(.IDLE_VAL(1'b1)) u_rst_n (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pin_i     (rst_n_i),
    .level_o   (),
    .rise_o    (),
    .fall_o    (n_fall)
  );

  // Floating write protect is expected to read low
  pin_sync_edge #(.IDLE_VAL(1'b0)) u_wp (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pin_i     (write_protect_i),
    .level_o   (wp_level),
    .rise_o    (),
    .fall_o    ()
  );

  assign kick_edge = kick_rise | kick_fall;
  // Edges are read only while released, so own drive never retriggers
  assign ext_req = hi_rise | n_fall;
  assign rst_active = (state_r != supervisor_pkg::ST_RUN);

  // Reset sequencer
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_r <= supervisor_pkg::ST_UNDERV;
    end else begin
      case (state_r)
        supervisor_pkg::ST_UNDERV: begin
          if (!undervolt_i) begin
            state_r <= supervisor_pkg::ST_TIMEOUT;
          end
        end
        supervisor_pkg::ST_TIMEOUT: begin
          if (undervolt_i) begin
            state_r <= supervisor_pkg::ST_UNDERV;
          end else if (pu_cnt_r == last_cnt(PURST_CYC)) begin
            state_r <= supervisor_pkg::ST_RUN;
          end
        end
        supervisor_pkg::ST_RUN: begin
          if (undervolt_i) begin
            state_r <= supervisor_pkg::ST_UNDERV;
          end else if (ext_req || wd_to) begin
            state_r <= supervisor_pkg::ST_TIMEOUT;
          end
        end
        default: begin
          state_r <= supervisor_pkg::ST_UNDERV;
        end
      endcase
    end
  end

  // Reset timeout counter, restarted on every entry
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || state_r != supervisor_pkg::ST_TIMEOUT) begin
      pu_cnt_r <= '0;
    end else if (pu_cnt_r != last_cnt(PURST_CYC)) begin
      pu_cnt_r <= pu_cnt_r + CW'(1);
    end
  end

  // Watchdog counter
  assign wd_to = (wd_cnt_r == last_cnt(WDOG_CYC));

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || rst_active) begin
      wd_cnt_r <= '0;
    end else if (kick_edge || wd_to) begin
      wd_cnt_r <= '0;
    end else begin
      wd_cnt_r <= wd_cnt_r + CW'(1);
    end
  end

  // Open-drain reset drive: only the asserted level is ever driven
  assign rst_hi_o    = 1'b1;
  assign rst_n_o     = 1'b0;
  assign rst_hi_oe_o = rst_active;
  assign rst_n_oe_o  = rst_active;

  // Internal write cycle
  assign prog_go = write_stop_i & ~wp_level & ~rst_active & ~busy_r;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      busy_r   <= 1'b0;
      start_r  <= 1'b0;
      wr_cnt_r <= '0;
    end else begin
      start_r <= prog_go;
      if (prog_go) begin
        busy_r   <= 1'b1;
        wr_cnt_r <= '0;
      end else if (busy_r) begin
        if (wr_cnt_r == last_cnt(WR_CYC)) begin
          busy_r <= 1'b0;
        end else begin
          wr_cnt_r <= wr_cnt_r + CW'(1);
        end
      end
    end
  end

  // Serial data pull-down, gated by reset and write cycle; data ack also gated by protect
  assign bus_en = ~busy_r & ~rst_active;

  always_comb begin
    sda_oe_nxt = 1'b0;
    if (bus_en) begin
      sda_oe_nxt = ack_addr_req_i | rd_low_req_i | (ack_data_req_i & ~wp_level);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // Line is never driven high
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_r;

  assign reset_active_o = rst_active;
  assign bus_enable_o   = bus_en;
  assign prog_start_o   = start_r;
  assign prog_busy_o    = busy_r;
  assign wdog_timeout_o = wd_to;

  // Checks
  property p_wd_timeout_len;
    @(posedge clk_sys_i) disable iff (srst_i)
      wd_to |-> (state_r == supervisor_pkg::ST_RUN) && (wd_cnt_r == last_cnt(WDOG_CYC));
  endproperty
  a_wd_timeout_len: assert property (p_wd_timeout_len) else $error("watchdog fired early");

  property p_kick_clears;
    @(posedge clk_sys_i) disable iff (srst_i)
      kick_edge |=> wd_cnt_r == '0;
  endproperty
  a_kick_clears: assert property (p_kick_clears) else $error("kick did not clear");

  property p_wd_resets;
    @(posedge clk_sys_i) disable iff (srst_i)
      (wd_to && !undervolt_i) |=> (state_r == supervisor_pkg::ST_TIMEOUT) && rst_hi_oe_o
        && rst_n_oe_o && pu_cnt_r == '0;
  endproperty
  a_wd_resets: assert property (p_wd_resets) else $error("no reset after timeout");

  property p_wd_held;
    @(posedge clk_sys_i) disable iff (srst_i)
      rst_active |=> wd_cnt_r == '0;
  endproperty
  a_wd_held: assert property (p_wd_held) else $error("watchdog counted in reset");

  property p_release_time;
    @(posedge clk_sys_i) disable iff (srst_i)
      $rose(state_r == supervisor_pkg::ST_RUN) |-> $past(pu_cnt_r) == last_cnt(PURST_CYC)
        && $past(state_r) == supervisor_pkg::ST_TIMEOUT;
  endproperty
  a_release_time: assert property (p_release_time) else $error("early release");

  property p_released;
    @(posedge clk_sys_i) disable iff (srst_i)
      (state_r == supervisor_pkg::ST_RUN) |-> !rst_hi_oe_o && !rst_n_oe_o;
  endproperty
  a_released: assert property (p_released) else $error("reset driven in run");

  property p_undervolt;
    @(posedge clk_sys_i) disable iff (srst_i)
      undervolt_i |=> (state_r == supervisor_pkg::ST_UNDERV) && rst_hi_oe_o && rst_n_oe_o;
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("undervoltage not reset");

  property p_ext_edge;
    @(posedge clk_sys_i) disable iff (srst_i)
      (ext_req && !undervolt_i && !rst_active) |=> (state_r == supervisor_pkg::ST_TIMEOUT)
        && pu_cnt_r == '0 ##1 rst_hi_oe_o;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("manual reset missed");

  property p_ext_low;
    @(posedge clk_sys_i) disable iff (srst_i)
      (n_fall && !undervolt_i && !rst_active) |=> rst_n_oe_o;
  endproperty
  a_ext_low: assert property (p_ext_low) else $error("low-line reset missed");

  property p_wp_block;
    @(posedge clk_sys_i) disable iff (srst_i)
      wp_level |=> !start_r;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("program under protect");

  property p_prog_len;
    @(posedge clk_sys_i) disable iff (srst_i)
      busy_r |-> wr_cnt_r <= last_cnt(WR_CYC);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("write cycle too long");

  property p_busy_quiet;
    @(posedge clk_sys_i) disable iff (srst_i)
      busy_r |=> !sda_oe_r;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus active in write");

  property p_reset_quiet;
    @(posedge clk_sys_i) disable iff (srst_i)
      rst_active |=> !sda_oe_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("ack during reset");

  c_wd_timeout: cover property (@(posedge clk_sys_i) disable iff (srst_i) wd_to);
  c_manual: cover property (@(posedge clk_sys_i) disable iff (srst_i) ext_req && !rst_active);
  c_prog: cover property (@(posedge clk_sys_i) disable iff (srst_i) start_r ##1 busy_r);
  c_powerup: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    $rose(state_r == supervisor_pkg::ST_RUN));

endmodule : supervisory_reset_watchdog
`default_nettype wire

/* test/host_partner.sv */
// Host side of the two open-drain reset wires, with their pull resistors
`timescale 1ns/1ps
`default_nettype none
module host_partner (
  // Device drive
  input  wire logic rst_hi_o_i,
  input  wire logic rst_hi_oe_i,
  input  wire logic rst_n_o_i,
  input  wire logic rst_n_oe_i,
  // Manual reset pushes by the host
  input  wire logic push_hi_i,
  input  wire logic push_lo_i,
  // Resolved wire levels
  output logic      rst_hi_line_o,
  output logic      rst_n_line_o
);
  // Pull-down on the high line, pull-up on the low line
  assign rst_hi_line_o = (rst_hi_oe_i & rst_hi_o_i) | push_hi_i;
  assign rst_n_line_o  = ~((rst_n_oe_i & ~rst_n_o_i) | push_lo_i);
endmodule : host_partner
`default_nettype wire

/* test/tb.sv */
// Self-checking bench of the supervisory reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned PURST = 20;
  localparam int unsigned WDOG  = 50;
  localparam int unsigned WR    = 10;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic uv = 1'b1, kick = 1'b0, push_hi = 1'b0, push_lo = 1'b0, wp = 1'b0;
  logic aa = 1'b0, ad = 1'b0, rl = 1'b0, ws = 1'b0;
  wire logic hi_line, n_line;
  logic hi_o, hi_oe, n_o, n_oe, sda_o, sda_oe, ra, be, ps, pb, wt;
  int mismatches = 0, n_checks = 0, n, i;
  int seed = 32'h1928;

  always #25 clk_sys_i = ~clk_sys_i;

  supervisory_reset_watchdog #(.PURST_CYC(PURST), .WDOG_CYC(WDOG), .WR_CYC(WR)) dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .undervolt_i(uv), .watchdog_kick_in_i(kick),
    .rst_hi_i(hi_line), .rst_hi_o(hi_o), .rst_hi_oe_o(hi_oe), .rst_n_i(n_line),
    .rst_n_o(n_o), .rst_n_oe_o(n_oe), .write_protect_i(wp), .ack_addr_req_i(aa),
    .ack_data_req_i(ad), .rd_low_req_i(rl), .write_stop_i(ws), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .reset_active_o(ra), .bus_enable_o(be), .prog_start_o(ps),
    .prog_busy_o(pb), .wdog_timeout_o(wt));

  host_partner host (
    .rst_hi_o_i(hi_o), .rst_hi_oe_i(hi_oe), .rst_n_o_i(n_o), .rst_n_oe_i(n_oe),
    .push_hi_i(push_hi), .push_lo_i(push_lo), .rst_hi_line_o(hi_line), .rst_n_line_o(n_line));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %0d exp %0d", $time, msg, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask : tick

  function automatic logic pick(input int sel);
    return (sel == 0) ? ra : (sel == 1) ? wt : pb;
  endfunction : pick

  // Bounded wait for a status level, cycles counted in cnt
  task automatic wait_for(input int sel, input logic lvl, output int cnt);
    cnt = 0;
    while (pick(sel) !== lvl) begin
      tick(1);
      cnt++;
      if (cnt > 400) begin
        mismatches++;
        $display("CHECK FAILED t=%0t wait ran out", $time);
        finish_test();
      end
    end
  endtask : wait_for

  // Model: release comes PURST cycles after the trigger, plus sync slack
  task automatic expect_release();
    wait_for(0, 1'b0, n);
    check(n >= PURST - 1 && n <= PURST + 4, 1'b1, "reset timeout length");
    check({hi_oe, n_oe, hi_line, n_line}, 4'b0001, "lines released");
  endtask : expect_release

  initial begin
    tick(4);
    check({ra, hi_oe, n_oe, sda_oe}, 4'b1110, "held in reset");
    srst_i = 1'b0;
    aa = 1'b1;
    tick(10);
    check({ra, hi_line, n_line, sda_oe}, 4'b1100, "undervoltage hold");
    aa = 1'b0;
    uv = 1'b0;
    expect_release();
    $display("test power-up done");
    // Kicks at random gaps keep the system running
    for (i = 0; i < 6; i++) begin
      tick(1 + ($unsigned($random(seed)) % (WDOG - 8)));
      kick = ~kick;
      check(ra, 1'b0, "kicked watchdog quiet");
    end
    wait_for(1, 1'b1, n);
    check(n >= WDOG - 2 && n <= WDOG + 4, 1'b1, "watchdog period");
    tick(1);
    check({ra, hi_oe, n_oe}, 3'b111, "watchdog reset");
    expect_release();
    // A counter running during reset would fire early here
    wait_for(1, 1'b1, n);
    check(n >= WDOG - 2 && n <= WDOG + 1, 1'b1, "watchdog held in reset");
    tick(1);
    check({ra, hi_oe, n_oe}, 3'b111, "second watchdog reset");
    expect_release();
    $display("test watchdog done");
    for (i = 0; i < 2; i++) begin
      kick = ~kick;
      tick(3);
      if (i == 0) push_hi = 1'b1;
      else push_lo = 1'b1;
      wait_for(0, 1'b1, n);
      check(n <= 5, 1'b1, "manual reset edge");
      check({hi_oe, n_oe}, 2'b11, "both lines driven");
      push_hi = 1'b0;
      push_lo = 1'b0;
      expect_release();
    end
    uv = 1'b1;
    tick(1);
    check({hi_oe, n_oe}, 2'b11, "brownout immediate");
    uv = 1'b0;
    expect_release();
    $display("test manual and brownout done");
    // Host waits only three cycles after release before bus traffic
    tick(3);
    kick = ~kick;
    ws = 1'b1;
    tick(1);
    ws = 1'b0;
    check({ps, pb, be}, 3'b110, "program start");
    aa = 1'b1;
    wait_for(2, 1'b0, n);
    check(n, WR, "write cycle length");
    check(sda_oe, 1'b0, "silent while busy");
    tick(1);
    check({sda_oe, sda_o}, 2'b10, "address ack low only");
    aa = 1'b0;
    ad = 1'b1;
    tick(2);
    check(sda_oe, 1'b1, "data ack open");
    ad = 1'b0;
    wp = 1'b1;
    tick(3);
    ws = 1'b1;
    tick(1);
    ws = 1'b0;
    check({ps, pb}, 2'b00, "protected no program");
    ad = 1'b1;
    tick(2);
    check(sda_oe, 1'b0, "protected data ack");
    ad = 1'b0;
    rl = 1'b1;
    tick(2);
    check({sda_oe, sda_o}, 2'b10, "read allowed");
    rl = 1'b0;
    wp = 1'b0;
    $display("test write gating done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
